/* verilog/qdg_pkg.sv */
package qdg_pkg;
   // register addresses on the control port
   localparam logic [7:0] ADDR_C_OFFSET    = 8'h0A;
   localparam logic [7:0] ADDR_D_OFFSET    = 8'h0B;
   localparam logic [7:0] ADDR_A_GAIN      = 8'h0C;
   localparam logic [7:0] ADDR_B_GAIN_MIX  = 8'h0D;
   localparam logic [7:0] ADDR_C_GAIN      = 8'h0E;
   localparam logic [7:0] ADDR_D_GAIN_DLY  = 8'h0F;
   localparam logic [7:0] ADDR_AB_PHASE    = 8'h10;
   // field layouts
   localparam int OFFSET_W    = 13;
   localparam int OFFSET_MSB  = 12;
   localparam int GAIN_W      = 11;
   localparam int GAIN_MSB    = 10;
   localparam int GAIN_FRAC   = 10;
   localparam int MIX_MSB     = 15;
   localparam int MIX_LSB     = 12;
   localparam int DLY_AB_MSB  = 15;
   localparam int DLY_AB_LSB  = 14;
   localparam int DLY_CD_MSB  = 13;
   localparam int DLY_CD_LSB  = 12;
   localparam int DLY_MAX     = 3;
   localparam int PHASE_MSB   = 11;
   // masks of assigned bits, the rest reads zero
   localparam logic [15:0] MASK_OFFSET  = 16'h1FFF;
   localparam logic [15:0] MASK_GAIN    = 16'h07FF;
   localparam logic [15:0] MASK_GAIN_HI = 16'hF7FF;
   localparam logic [15:0] MASK_PHASE   = 16'h0FFF;
   // reset values
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [15:0] RST_GAIN   = 16'h0400;
   localparam logic [15:0] RST_PHASE  = 16'h0000;
   // coarse mixer bit order within the mix field
   localparam int MIX_FS8  = 3;
   localparam int MIX_FS4  = 2;
   localparam int MIX_FS2  = 1;
   localparam int MIX_NFS4 = 0;
endpackage

/* verilog/qdg_regs.sv */
`timescale 1ns/1ps
module qdg_regs
   import qdg_pkg::*;
#(
   parameter int SAMPLE_W = 16
)
(
   input  wire logic                       mclk,
   input  wire logic                       reset,
   input  wire logic [7:0]                 addr,
   input  wire logic [15:0]                wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output logic      [15:0]                rdata,
   input  wire logic                       in_valid,
   input  wire logic signed [SAMPLE_W-1:0] in_a,
   input  wire logic signed [SAMPLE_W-1:0] in_b,
   input  wire logic signed [SAMPLE_W-1:0] in_c,
   input  wire logic signed [SAMPLE_W-1:0] in_d,
   output logic signed [SAMPLE_W-1:0]      out_a,
   output logic signed [SAMPLE_W-1:0]      out_b,
   output logic signed [SAMPLE_W-1:0]      out_c,
   output logic signed [SAMPLE_W-1:0]      out_d,
   output logic      [3:0]                 mix_phase
);

   // structure, in short:
   // - five software images, written from the control port
   // - shadow copies for the words that wait for a load trigger
   // - a direct decode of the words that act at once
   // - a registered read mux, so rdata is zero outside a read
   // - a coarse mixer phase accumulator
   // - four gain channels, with an offset on channel D only, feeding per-pair delay lines
   // the C offset and AB phase registers themselves live outside
   // this bank; only their write strobes are seen here, as triggers
   // everything runs on mclk; in_valid is the sample rate enable
   // reset is synchronous and active high throughout
   // rdata and every sample output are registered
   // latency from in_a..in_d to out_a..out_d is one sample plus one cycle plus delay

   // software-visible images
   logic [15:0] reg_d_offset;
   logic [15:0] reg_a_gain;
   logic [15:0] reg_b_gain_mix;
   logic [15:0] reg_c_gain;
   logic [15:0] reg_d_gain_dly;
   // applied values
   // C/D gain, mixer and delay words are plain copies of the images;
   // D offset and A/B gains are shadows with their own load strobes
   logic [OFFSET_MSB:0] chan_d_offset_word;
   logic [GAIN_MSB:0]   chan_a_gain_word;
   logic [GAIN_MSB:0]   chan_b_gain_word;
   logic [GAIN_MSB:0]   chan_c_gain_word;
   logic [GAIN_MSB:0]   chan_d_gain_word;
   logic [1:0]          pair_ab_out_delay;
   logic [1:0]          pair_cd_out_delay;
   logic [3:0]          cmix_sel;
   logic [2:0]          mix_step;
   logic [2:0]          mix_acc;

   // register writes; masking keeps reserved bits zero
   // reserved bits are dropped on the way in, not on the way out,
   // so the stored image and the read value can never disagree
   // writes to unmapped addresses are silently ignored
   // bit 11 is reserved in the mixed registers too, hence MASK_GAIN_HI
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         reg_d_offset   <= RST_OFFSET;
         reg_a_gain     <= RST_GAIN;
         reg_b_gain_mix <= RST_GAIN;
         reg_c_gain     <= RST_GAIN;
         reg_d_gain_dly <= RST_GAIN;
      end
      else if (wr)
      begin
         case (addr)
            ADDR_D_OFFSET:   reg_d_offset   <= wdata & MASK_OFFSET;
            ADDR_A_GAIN:     reg_a_gain     <= wdata & MASK_GAIN;
            ADDR_B_GAIN_MIX: reg_b_gain_mix <= wdata & MASK_GAIN_HI;
            ADDR_C_GAIN:     reg_c_gain     <= wdata & MASK_GAIN;
            ADDR_D_GAIN_DLY: reg_d_gain_dly <= wdata & MASK_GAIN_HI;
            default: ;
         endcase
      end
   end

   // applied D offset loads only with the C offset write
   // the D word alone never reaches the datapath; software must
   // finish with the C offset write so both offsets change together
   // the shadow copies the image as it stood before that write edge
   // reset clears the applied word, matching the image reset
   always_ff @(posedge mclk)
   begin
      if (reset)
         chan_d_offset_word <= '0;
      else if (wr && addr == ADDR_C_OFFSET)
         chan_d_offset_word <= reg_d_offset[OFFSET_MSB:0];
   end

   // A/B gains load with the AB phase write; C, D, mixer, delays apply at once
   // the phase register write is the single strobe that moves both
   // gains, avoiding a one-sample mismatch between A and B while
   // software updates them; reset value equals the image reset
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         chan_a_gain_word <= RST_GAIN[GAIN_MSB:0];
         chan_b_gain_word <= RST_GAIN[GAIN_MSB:0];
      end
      else if (wr && addr == ADDR_AB_PHASE)
      begin
         chan_a_gain_word <= reg_a_gain[GAIN_MSB:0];
         chan_b_gain_word <= reg_b_gain_mix[GAIN_MSB:0];
      end
   end

   // C/D gains, mixer and delays follow the registers directly
   // no shadow here: these fields take effect on the next sample
   // a change of delay in mid-stream can repeat or skip samples;
   // software should change it while the stream is idle
   always_comb
   begin
      chan_c_gain_word  = reg_c_gain[GAIN_MSB:0];
      chan_d_gain_word  = reg_d_gain_dly[GAIN_MSB:0];
      cmix_sel          = reg_b_gain_mix[MIX_MSB:MIX_LSB];
      pair_ab_out_delay = reg_d_gain_dly[DLY_AB_MSB:DLY_AB_LSB];
      pair_cd_out_delay = reg_d_gain_dly[DLY_CD_MSB:DLY_CD_LSB];
   end

   // read data one cycle after the strobe; unmapped reads zero
   // zero outside a read cycle keeps a shared read bus quiet
   // and makes a stray sample of rdata harmless
   // reads have no side effects on any register
   always_ff @(posedge mclk)
   begin
      if (reset)
         rdata <= 16'h0000;
      else if (rd)
      begin
         case (addr)
            ADDR_D_OFFSET:   rdata <= reg_d_offset;
            ADDR_A_GAIN:     rdata <= reg_a_gain;
            ADDR_B_GAIN_MIX: rdata <= reg_b_gain_mix;
            ADDR_C_GAIN:     rdata <= reg_c_gain;
            ADDR_D_GAIN_DLY: rdata <= reg_d_gain_dly;
            default:         rdata <= 16'h0000;
         endcase
      end
      else
         rdata <= 16'h0000;
   end

   // cascaded mixers: each adds its step in eighths of Fs
   // the four mixers shift by +1, +2, +4 and -2 eighths of Fs;
   // cascading them is a sum modulo eight, so a 3-bit adder suffices
   // -Fs/4 is added as its two's complement, 3'h6 after wrap
   // e.g. Fs/8 with -Fs/4 gives -Fs/8, a step of 7
   always_comb
   begin
      mix_step = 3'h0;
      if (cmix_sel[MIX_FS8])
         mix_step = mix_step + 3'h1;
      if (cmix_sel[MIX_FS4])
         mix_step = mix_step + 3'h2;
      if (cmix_sel[MIX_FS2])
         mix_step = mix_step + 3'h4;
      if (cmix_sel[MIX_NFS4])
         mix_step = mix_step - 3'h2;
   end

   // phase accumulator in eighths of a turn, one step per sample
   // it only moves with in_valid, so a paused stream keeps its phase;
   // it is not cleared when the mix changes
   // wraps naturally at eight, one full turn of the carrier
   always_ff @(posedge mclk)
   begin
      if (reset)
         mix_acc <= 3'h0;
      else if (in_valid)
         mix_acc <= mix_acc + mix_step;
   end

   // exported rotation: accumulated mixer phase, the top bit flags any mixer on
   // bit 3 lets the consumer bypass the rotator when no mixer is on,
   // which saves power in the common unmixed case
   always_ff @(posedge mclk)
   begin
      if (reset)
         mix_phase <= 4'h0;
      else
         mix_phase <= {(cmix_sel != 4'h0), mix_acc};
   end

   // gain and offset datapath, saturating to the sample width
   // product width: sample plus gain plus one guard bit for the
   // zero-extended unsigned gain; the shift by ten fraction bits
   // then brings unity gain back to the input scale
   // saturation rather than wrap: a gain near two or an offset
   // near full scale would otherwise flip the sign of the output
   // the offset is taken as a 13-bit two's complement word
   localparam int PROD_W = SAMPLE_W + GAIN_W + 1;
   logic signed [SAMPLE_W-1:0] in_s   [4];
   logic signed [SAMPLE_W-1:0] corr_s [4];
   logic        [GAIN_MSB:0]   gain_s [4];
   logic signed [SAMPLE_W-1:0] dly_line [4][DLY_MAX+1];

   assign in_s[0]   = in_a;
   assign in_s[1]   = in_b;
   assign in_s[2]   = in_c;
   assign in_s[3]   = in_d;
   assign gain_s[0] = chan_a_gain_word;
   assign gain_s[1] = chan_b_gain_word;
   assign gain_s[2] = chan_c_gain_word;
   assign gain_s[3] = chan_d_gain_word;

   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++)
      begin : g_chan
         logic signed [PROD_W-1:0] prod;
         logic signed [PROD_W-1:0] scaled;
         logic signed [PROD_W-1:0] summed;
         logic signed [PROD_W-1:0] lim_hi;
         logic signed [PROD_W-1:0] lim_lo;
         // unsigned gain, ten fraction bits
         // gain widened by a zero so the signed multiply keeps it positive
         assign prod   = PROD_W'(in_s[ch]) * $signed({1'b0, gain_s[ch]});
         assign scaled = prod >>> GAIN_FRAC;
         // offset only exists for channel D in this bank
         assign summed = (ch == 3) ? scaled + PROD_W'($signed(chan_d_offset_word)) : scaled;
         // limits are built at full product width to compare signed values
         assign lim_hi = PROD_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
         assign lim_lo = -lim_hi - PROD_W'(1);
         assign corr_s[ch] = (summed > lim_hi) ? lim_hi[SAMPLE_W-1:0] :
                             (summed < lim_lo) ? lim_lo[SAMPLE_W-1:0] :
                             summed[SAMPLE_W-1:0];
         // delay taps: tap 0 is the registered corrected sample
         // taps shift only on in_valid, so delay is counted in samples;
         // with in_valid high every cycle that is one DAC clock per step
         // tap 3 is the oldest sample, three samples behind tap 0
         always_ff @(posedge mclk)
         begin
            if (reset)
               for (int t = 0; t <= DLY_MAX; t++)
                  dly_line[ch][t] <= '0;
            else if (in_valid)
            begin
               dly_line[ch][0] <= corr_s[ch];
               for (int t = 1; t <= DLY_MAX; t++)
                  dly_line[ch][t] <= dly_line[ch][t-1];
            end
         end
      end
   endgenerate

   // output tap select per pair, registered at the pins
   // the extra register keeps every output straight from a flop;
   // it adds one fixed cycle of latency common to all four lanes
   // taps are indexed by the live delay field, no glitch-free switching
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         out_a <= '0;
         out_b <= '0;
         out_c <= '0;
         out_d <= '0;
      end
      else
      begin
         out_a <= dly_line[0][pair_ab_out_delay];
         out_b <= dly_line[1][pair_ab_out_delay];
         out_c <= dly_line[2][pair_cd_out_delay];
         out_d <= dly_line[3][pair_cd_out_delay];
      end
   end

endmodule

/* testbench/qdg_regs_assertions.sv */
`timescale 1ns/1ps
module qdg_regs_checker
   import qdg_pkg::*;
#(parameter int SAMPLE_W = 16)
(
   input wire logic                       mclk,
   input wire logic                       reset,
   input wire logic [7:0]                 addr,
   input wire logic [15:0]                wdata,
   input wire logic                       wr,
   input wire logic                       rd,
   input wire logic [15:0]                rdata,
   input wire logic signed [SAMPLE_W-1:0] out_d,
   input wire logic [3:0]                 mix_phase
);
   // single domain, so clock and reset are stated once
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_wr_rd(logic [7:0] a); wr && addr == a ##1 rd && addr == a; endsequence
   property p_idle; !rd |=> rdata == 16'h0000; endproperty
   property p_off; rd && addr == ADDR_D_OFFSET |=> rdata[15:13] == 3'h0; endproperty
   property p_gain; rd && (addr == ADDR_A_GAIN || addr == ADDR_C_GAIN) |=> rdata[15:11] == 5'h00;
   endproperty
   property p_rsv; rd && addr[7:2] == 6'h03 && addr[0] |=> !rdata[11]; endproperty
   property p_mix; s_wr_rd(ADDR_B_GAIN_MIX) |=> rdata == ($past(wdata, 2) & MASK_GAIN_HI);
   endproperty
   property p_dly; s_wr_rd(ADDR_D_GAIN_DLY) |=> rdata == ($past(wdata, 2) & MASK_GAIN_HI);
   endproperty
   property p_unmap; rd && (addr < ADDR_D_OFFSET || addr > ADDR_D_GAIN_DLY) |=> rdata == 16'h0000;
   endproperty
   property p_rst; $fell(reset) |-> out_d == 0 && mix_phase == 4'h0 && rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   a_off: assert property (p_off) else $error("offset high bits set");
   a_gain: assert property (p_gain) else $error("gain high bits set");
   a_rsv: assert property (p_rsv) else $error("bit 11 set");
   a_mix: assert property (p_mix) else $error("mix word lost");
   a_dly: assert property (p_dly) else $error("delay word lost");
   a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
   a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule

bind qdg_regs qdg_regs_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (.mclk(mclk), .reset(reset),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .out_d(out_d),
   .mix_phase(mix_phase));

/* testbench/test_quad_dac_gain_mix_delay_regs.sv */
`timescale 1ns/1ps
module test_quad_dac_gain_mix_delay_regs
   import qdg_pkg::*;
;
   logic               mclk = 1'b0;
   logic               reset = 1'b1;
   logic [7:0]         addr = 8'h00;
   logic [15:0]        wdata = 16'h0000;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic               in_valid = 1'b0;
   logic signed [15:0] in_x [4];
   wire signed [15:0]  out_x [4];
   wire [15:0]         rdata;
   wire [3:0]          mix_phase;
   logic [15:0]        rm [256];
   logic [15:0]        erd = 16'h0000;
   int                 ag [2];
   int                 doff, na, nc, p0;
   int                 fails = 0;
   int                 compares = 0;
   int                 seed = 21129;

   always #5 mclk = ~mclk;

   qdg_regs #(.SAMPLE_W(16)) uut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .in_valid(in_valid), .in_a(in_x[0]), .in_b(in_x[1]),
      .in_c(in_x[2]), .in_d(in_x[3]), .out_a(out_x[0]), .out_b(out_x[1]), .out_c(out_x[2]),
      .out_d(out_x[3]), .mix_phase(mix_phase));

   task conclude;
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one bus cycle, every signal changed once just after the edge
   task bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
   endtask

   function automatic logic [15:0] msk(logic [7:0] a);
      case (a)
         ADDR_D_OFFSET: return MASK_OFFSET;
         ADDR_A_GAIN, ADDR_C_GAIN: return MASK_GAIN;
         ADDR_B_GAIN_MIX, ADDR_D_GAIN_DLY: return MASK_GAIN_HI;
         default: return 16'h0000;
      endcase
   endfunction

   // expected steady output of one channel; saturates to the sample width like the design
   function automatic logic [15:0] ex(int ch);
      int v;
      v = (int'(in_x[ch]) * (ch < 2 ? ag[ch & 1] : int'(rm[12 + ch] & MASK_GAIN))) >>> 10;
      if (ch == 3)
         v += doff;
      v = v > 32767 ? 32767 : v < -32768 ? -32768 : v;
      return v[15:0];
   endfunction

   // hold inputs until every delay tap has flushed, then compare
   task settle;
      repeat (8) bus(0, 0, 8'h00, 16'h0000);
      for (int ch = 0; ch < 4; ch++)
         check(out_x[ch], ex(ch));
   endtask

   // reference bank, staged values load on the same edges as the design
   always @(posedge mclk)
   begin
      if (!reset)
         check(rdata, erd);
      erd <= (rd && !reset) ? rm[addr] : 16'h0000;
      if (reset)
      begin
         rm[ADDR_D_OFFSET] <= RST_OFFSET;
         for (int k = 12; k < 16; k++)
            rm[k] <= RST_GAIN;
         ag <= '{1024, 1024};
         doff <= 0;
      end
      else if (wr)
      begin
         rm[addr] <= wdata & msk(addr);
         if (addr == ADDR_C_OFFSET)
            doff <= int'({{19{rm[11][12]}}, rm[11][12:0]});
         if (addr == ADDR_AB_PHASE)
            ag <= '{int'(rm[12] & MASK_GAIN), int'(rm[13] & MASK_GAIN)};
      end
   end

   initial
   begin
      foreach (rm[k]) rm[k] = 16'h0000;
      foreach (in_x[k]) in_x[k] = 16'sh0000;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      in_valid <= 1'b1;
      for (int a = 8; a < 20; a++) bus(0, 1, 8'(a), 16'h0000);
      repeat (3) for (int a = 10; a < 17; a++)
      begin
         bus(1, 0, 8'(a), 16'($random(seed)));
         bus(0, 1, 8'(a), 16'h0000);
      end
      for (int j = 0; j < 3; j++)
      begin
         foreach (in_x[k]) in_x[k] <= k == 3 ? 16'($random(seed) % 4096) : 16'($random(seed));
         settle();
         for (int a = 11; a < 16; a++) bus(1, 0, 8'(a), j == 0 ? 16'hFFFF : 16'($random(seed)));
         settle();
         bus(1, 0, ADDR_C_OFFSET, 16'h0000);
         settle();
         bus(1, 0, ADDR_AB_PHASE, 16'h0000);
         settle();
      end
      for (int k = 12; k < 15; k++) bus(1, 0, 8'(k), RST_GAIN);
      bus(1, 0, ADDR_AB_PHASE, 16'h0000);
      for (int j = 0; j < 4; j++)
      begin
         bus(1, 0, ADDR_D_GAIN_DLY, {2'(j), 2'(3 - j), 12'h400});
         foreach (in_x[k]) in_x[k] <= 16'sh0000;
         settle();
         foreach (in_x[k]) in_x[k] <= 16'($random(seed)) | 16'h0001;
         na = 0;
         nc = 0;
         for (int n = 1; n < 12; n++)
         begin
            bus(0, 0, 8'h00, 16'h0000);
            if (na == 0 && out_x[0] === ex(0)) na = n;
            if (nc == 0 && out_x[2] === ex(2)) nc = n;
         end
         check(16'(na), 16'(3 + j));
         check(16'(nc), 16'(6 - j));
      end
      for (int c = 0; c < 16; c++)
      begin
         bus(1, 0, ADDR_B_GAIN_MIX, {4'(c), 12'h400});
         repeat (4) bus(0, 0, 8'h00, 16'h0000);
         p0 = mix_phase;
         bus(0, 0, 8'h00, 16'h0000);
         check(mix_phase, {c != 0, 3'(p0 + c[3] + 2 * c[2] + 4 * c[1] + 6 * c[0])});
      end
      // in_valid low freezes the mixer phase
      bus(1, 0, ADDR_B_GAIN_MIX, 16'h8400);
      in_valid <= 1'b0;
      repeat (3) bus(0, 0, 8'h00, 16'h0000);
      p0 = mix_phase;
      bus(0, 0, 8'h00, 16'h0000);
      check(mix_phase, 16'(p0));
      conclude();
   end
endmodule
